// ==== hw/can_mo_defines.svh ====
// Register offsets, field positions, reset values and timing figures of the message object controller.
// Assumes inclusion by bare name from the design modules.
`ifndef CAN_MO_DEFINES_SVH
`define CAN_MO_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_TX_OUTPUT_CONFIG 8'h02
`define ADDR_RX_IRQ_ENABLE_LOW 8'h06
`define ADDR_RX_IRQ_ENABLE_HIGH 8'h07
`define ADDR_RX_READY_LOW 8'h08
`define ADDR_RX_READY_HIGH 8'h09
`define ADDR_IRQ_SOURCE_ENABLE 8'h0a
`define ADDR_TX_REQUEST_LOW 8'h0c
`define ADDR_TX_REQUEST_HIGH 8'h0d
`define ADDR_OPERATING_CONTROL 8'h10
`define ADDR_CLOCK_OUT_DIVIDER 8'h14
`define DESC_REGION 3'h1
`define DATA_REGION_BIT 7

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define MODE_INIT_BIT 0
`define MODE_RESET_BIT 1
`define MODE_TX_DONE_BIT 5
`define MODE_RESET_VALUE 8'h03
`define IRQ_RX_BIT 0
`define IRQ_TX_DONE_BIT 7
`define OC_INVERT_BIT 2
`define CCR_UNLOCK 8'h80
`define CCR_OFF_BIT 3

// ----------------------------------------
// Frame layout and timing
// ----------------------------------------
`define FRAME_HDR_BITS 7'd17
`define FRAME_EOF_BITS 7'd10
`define MAX_DATA_BYTES 4'h8
`define CLK_FREQ_MHZ 50
`define BIT_TIME_NS 1000
`define BIT_CYCLES ((`BIT_TIME_NS * `CLK_FREQ_MHZ) / 1000)

`endif

// ==== hw/can_mo_pkg.sv ====
// Types shared by the message object controller files.
// Assumes the defines header is compiled alongside.
package can_mo_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TX = 3'b010,
    ST_RX = 3'b100
  } link_state_e;
  typedef logic [3:0] obj_idx_t;
endpackage : can_mo_pkg

// ==== hw/clk_out_if.sv ====
// Carrier between the controller and its clock output divider.
// Assumes both ends run on mclk.
`timescale 1ns/1ns
interface clk_out_if;
  logic [3:0] sel;
  logic clk_q;
  modport ctrl (output sel, input clk_q);
  modport gen (input sel, output clk_q);
endinterface : clk_out_if

// ==== hw/clock_out_gen.sv ====
// Divider for the clock output pin: even ratios 2 to 14 or off.
// Assumes the selection code from the clock control register; ratio 1 is bypassed by the caller.
`timescale 1ns/1ns
`include "can_mo_defines.svh"
module clock_out_gen
  import can_mo_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  clk_out_if.gen port
);
  logic [2:0] cnt_reg;
  logic q_reg;
  wire idle = port.sel[`CCR_OFF_BIT] || (port.sel[2:0] == 3'h0);
  wire wrap = (cnt_reg == port.sel[2:0] - 3'h1);

  // Half period is the code itself, so code n gives a ratio of 2n.
  always_ff @(posedge mclk) begin
    if (!rstn || idle) begin
      cnt_reg <= 3'h0;
      q_reg <= 1'b0;
    end else if (wrap) begin
      cnt_reg <= 3'h0;
      q_reg <= ~q_reg;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  assign port.clk_q = q_reg;
endmodule : clock_out_gen

// ==== hw/can_mo_ctrl.sv ====
// Full CAN controller with sixteen message objects behind a byte register port.
// Assumes a host on mclk using one-cycle strobes and a transceiver on tx and rx pins.
// Overview of operation
// - Bit 0 of the interrupt source enable lets receptions raise the host interrupt.
// - Bit 7 enables the tx complete interrupt; bits 6 to 1 have no effect.
// - Two receive enable registers gate each object's receive interrupt.
// - Host sets output config; default drives low for dominant, high for recessive.
// - Clock output divides by 1,2,4,...,14 or is off.
// - Clock control accepts a value only as the next access after an unlock write.
// - Data objects send data frames, store data, ignore remote frames.
// - Remote objects send remote frames, ignore data, answer remote frames.
// - Answer to an own remote frame lands only in a data object.
// - Objects cannot be disabled; descriptors are undefined after reset.
// - Data writes fill a shadow; writing byte 0 commits all eight.
// - Reset and init bits set hold the device in configuration.
// - Clearing both bits lets the device join bus traffic.
// - Setting a transmit request bit starts that object's transmission.
// - Pending requests are sent highest object number first.
// - Length code decides how many data bytes are sent.
// - Tx done flag is set after a successful transmission.
// - A remote object switched to data stores the answer unless outranked.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`include "can_mo_defines.svh"
module can_mo_ctrl
  import can_mo_pkg::*;
#(
  parameter int BIT_CYCLES = `BIT_CYCLES
)(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic rx_pin,
  output logic tx_output_pin,
  output logic clk_out,
  output logic irq_n
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] tx_output_config_reg, rx_irq_enable_low_reg, rx_irq_enable_high_reg;
  logic [7:0] irq_source_enable_reg, clock_out_divider_reg, operating_control_reg;
  logic [15:0] tx_req_reg, tx_req_next, rx_ready_reg, rx_ready_next, answer_reg, answer_next;
  logic ccr_armed_reg, irq_n_reg, tx_pin_reg;
  logic [7:0] rdata_reg, read_mux;
  logic [7:0] data_mem [0:127];
  logic [7:0] shadow_reg [1:7];
  logic [10:0] desc_id [0:15];
  logic [3:0] desc_dlc [0:15];
  logic [15:0] desc_rtr;
  link_state_e state_reg;
  obj_idx_t cur_obj_reg, pick, obj_data, obj_rem;
  logic is_remote_reg, tx_bit, hit_data, hit_rem;
  logic [6:0] pos_reg;
  logic [10:0] rx_id_reg;
  logic rx_rtr_reg;
  logic [3:0] rx_dlc_reg;
  logic [63:0] rx_data_reg;
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_level_reg;
  logic [15:0] bit_cnt_reg;
  clk_out_if clkif ();

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_mode = wr_en && (addr == `ADDR_OPERATING_CONTROL);
  wire wr_ccr = wr_en && (addr == `ADDR_CLOCK_OUT_DIVIDER);
  wire wr_req_lo = wr_en && (addr == `ADDR_TX_REQUEST_LOW);
  wire wr_req_hi = wr_en && (addr == `ADDR_TX_REQUEST_HIGH);
  wire wr_rdy_lo = wr_en && (addr == `ADDR_RX_READY_LOW);
  wire wr_rdy_hi = wr_en && (addr == `ADDR_RX_READY_HIGH);
  wire data_sel = addr[`DATA_REGION_BIT];
  wire desc_sel = (addr[7:5] == `DESC_REGION);
  wire wr_data = wr_en && data_sel;
  wire wr_desc = wr_en && desc_sel;
  wire [3:0] data_obj = addr[6:3];
  wire [2:0] data_byte = addr[2:0];
  wire [3:0] desc_obj = addr[4:1];
  wire ccr_unlock = (wdata == `CCR_UNLOCK);
  wire ccr_take = wr_ccr && ccr_armed_reg && !ccr_unlock;
  wire link_enable = !operating_control_reg[`MODE_INIT_BIT] && !operating_control_reg[`MODE_RESET_BIT];
  wire [15:0] rx_irq_mask = {rx_irq_enable_high_reg, rx_irq_enable_low_reg};
  wire bit_tick = (bit_cnt_reg == 16'(BIT_CYCLES - 1));

  // ----------------------------------------
  // Transmit scheduling and serialising
  // ----------------------------------------
  // A later set bit overrides, so the highest pending object wins.
  always_comb begin
    pick = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (tx_req_reg[i]) begin
        pick = 4'(i);
      end
    end
  end
  wire [15:0] higher_pending = (tx_req_reg >> pick) >> 1;
  wire tx_start = (state_reg == ST_IDLE) && bit_tick && link_enable && (|tx_req_reg) && rx_level_reg;
  wire [3:0] tx_dlc = desc_dlc[cur_obj_reg];
  wire [3:0] tx_nb = is_remote_reg ? 4'h0 : ((tx_dlc > `MAX_DATA_BYTES) ? `MAX_DATA_BYTES : tx_dlc);
  wire [6:0] tx_data_end = `FRAME_HDR_BITS + {tx_nb, 3'h0};
  wire tx_done = (state_reg == ST_TX) && bit_tick && (pos_reg == tx_data_end + `FRAME_EOF_BITS - 7'd1);
  wire [6:0] data_pos = pos_reg - `FRAME_HDR_BITS;
  wire [7:0] tx_byte = data_mem[{cur_obj_reg, data_pos[5:3]}];

  always_comb begin
    if (pos_reg == 7'd0) begin
      tx_bit = 1'b0;
    end else if (pos_reg <= 7'd11) begin
      tx_bit = desc_id[cur_obj_reg][4'(7'd11 - pos_reg)];
    end else if (pos_reg == 7'd12) begin
      tx_bit = is_remote_reg;
    end else if (pos_reg < `FRAME_HDR_BITS) begin
      tx_bit = tx_dlc[2'(7'd16 - pos_reg)];
    end else if (pos_reg < tx_data_end) begin
      tx_bit = tx_byte[~data_pos[2:0]];
    end else begin
      tx_bit = 1'b1;
    end
  end

  // ----------------------------------------
  // Receive framing and acceptance
  // ----------------------------------------
  wire rx_start = (state_reg == ST_IDLE) && bit_tick && link_enable && !tx_start && !rx_level_reg;
  wire [3:0] rx_nb = rx_rtr_reg ? 4'h0 : ((rx_dlc_reg > `MAX_DATA_BYTES) ? `MAX_DATA_BYTES : rx_dlc_reg);
  wire rx_end = (state_reg == ST_RX) && bit_tick && (pos_reg > 7'd16) &&
                (pos_reg == `FRAME_HDR_BITS + {rx_nb, 3'h0});

  // The higher object number wins when identifiers overlap.
  always_comb begin
    hit_data = 1'b0;
    hit_rem = 1'b0;
    obj_data = 4'h0;
    obj_rem = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (desc_id[i] == rx_id_reg) begin
        if (!desc_rtr[i]) begin
          hit_data = 1'b1;
          obj_data = 4'(i);
        end else begin
          hit_rem = 1'b1;
          obj_rem = 4'(i);
        end
      end
    end
  end
  wire rx_store = rx_end && !rx_rtr_reg && hit_data;
  wire rx_answer = rx_end && rx_rtr_reg && hit_rem;

  // ----------------------------------------
  // Link state machine
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bit_cnt_reg <= 16'h0;
    end else begin
      bit_cnt_reg <= bit_tick ? 16'h0 : bit_cnt_reg + 16'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      pos_reg <= 7'd0;
      cur_obj_reg <= 4'h0;
      is_remote_reg <= 1'b0;
    end else if (!link_enable) begin
      state_reg <= ST_IDLE;
      pos_reg <= 7'd0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (tx_start) begin
            state_reg <= ST_TX;
            cur_obj_reg <= pick;
            is_remote_reg <= desc_rtr[pick] && !answer_reg[pick];
            pos_reg <= 7'd0;
          end else if (rx_start) begin
            state_reg <= ST_RX;
            pos_reg <= 7'd1;
          end
        end
        ST_TX: begin
          if (tx_done) begin
            state_reg <= ST_IDLE;
          end else if (bit_tick) begin
            pos_reg <= pos_reg + 7'd1;
          end
        end
        ST_RX: begin
          if (rx_end) begin
            state_reg <= ST_IDLE;
          end else if (bit_tick) begin
            pos_reg <= pos_reg + 7'd1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_id_reg <= 11'h0;
      rx_rtr_reg <= 1'b0;
      rx_dlc_reg <= 4'h0;
      rx_data_reg <= 64'h0;
    end else if ((state_reg == ST_RX) && bit_tick && !rx_end) begin
      if (pos_reg <= 7'd11) begin
        rx_id_reg <= {rx_id_reg[9:0], rx_level_reg};
      end else if (pos_reg == 7'd12) begin
        rx_rtr_reg <= rx_level_reg;
      end else if (pos_reg < `FRAME_HDR_BITS) begin
        rx_dlc_reg <= {rx_dlc_reg[2:0], rx_level_reg};
      end else begin
        rx_data_reg[{data_pos[5:3], ~data_pos[2:0]}] <= rx_level_reg;
      end
    end
  end

  // A pin level counts only once the second and third stage agree.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
      rx_level_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg) begin
        rx_level_reg <= rx_s3_reg;
      end
    end
  end

  // ----------------------------------------
  // Message memory and descriptors
  // ----------------------------------------
  // Descriptors carry no reset, so unused objects must be given a dead identifier.
  always_ff @(posedge mclk) begin
    if (rx_store) begin
      for (int k = 0; k < 8; k++) begin
        if (4'(k) < rx_nb) begin
          data_mem[{obj_data, 3'(k)}] <= rx_data_reg[8 * k +: 8];
        end
      end
      desc_dlc[obj_data] <= rx_dlc_reg;
    end
    if (wr_data && (data_byte != 3'h0)) begin
      shadow_reg[data_byte] <= wdata;
    end
    if (wr_data && (data_byte == 3'h0)) begin
      data_mem[{data_obj, 3'h0}] <= wdata;
      for (int k = 1; k < 8; k++) begin
        data_mem[{data_obj, 3'(k)}] <= shadow_reg[k];
      end
    end
    if (wr_desc && !addr[0]) begin
      desc_id[desc_obj][2:0] <= wdata[7:5];
      desc_rtr[desc_obj] <= wdata[4];
      desc_dlc[desc_obj] <= wdata[3:0];
    end
    if (wr_desc && addr[0]) begin
      desc_id[desc_obj][10:3] <= wdata;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Hardware sets are applied after software clears, so a same-cycle event survives.
  always_comb begin
    tx_req_next = tx_req_reg;
    answer_next = answer_reg;
    rx_ready_next = rx_ready_reg;
    if (tx_done) begin
      tx_req_next[cur_obj_reg] = 1'b0;
      answer_next[cur_obj_reg] = 1'b0;
    end
    if (wr_req_lo) begin
      tx_req_next[7:0] = tx_req_next[7:0] | wdata;
    end
    if (wr_req_hi) begin
      tx_req_next[15:8] = tx_req_next[15:8] | wdata;
    end
    if (wr_rdy_lo) begin
      rx_ready_next[7:0] = rx_ready_next[7:0] & wdata;
    end
    if (wr_rdy_hi) begin
      rx_ready_next[15:8] = rx_ready_next[15:8] & wdata;
    end
    if (rx_answer) begin
      tx_req_next[obj_rem] = 1'b1;
      answer_next[obj_rem] = 1'b1;
    end
    if (rx_store) begin
      rx_ready_next[obj_data] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_req_reg <= 16'h0;
      answer_reg <= 16'h0;
      rx_ready_reg <= 16'h0;
    end else begin
      tx_req_reg <= tx_req_next;
      answer_reg <= answer_next;
      rx_ready_reg <= rx_ready_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      operating_control_reg <= `MODE_RESET_VALUE;
      tx_output_config_reg <= 8'h00;
      rx_irq_enable_low_reg <= 8'h00;
      rx_irq_enable_high_reg <= 8'h00;
      irq_source_enable_reg <= 8'h00;
    end else begin
      if (wr_mode) begin
        operating_control_reg <= wdata;
      end
      if (tx_done) begin
        operating_control_reg[`MODE_TX_DONE_BIT] <= 1'b1;
      end
      if (wr_en && (addr == `ADDR_TX_OUTPUT_CONFIG)) begin
        tx_output_config_reg <= wdata;
      end
      if (wr_en && (addr == `ADDR_RX_IRQ_ENABLE_LOW)) begin
        rx_irq_enable_low_reg <= wdata;
      end
      if (wr_en && (addr == `ADDR_RX_IRQ_ENABLE_HIGH)) begin
        rx_irq_enable_high_reg <= wdata;
      end
      if (wr_en && (addr == `ADDR_IRQ_SOURCE_ENABLE)) begin
        irq_source_enable_reg <= wdata;
      end
    end
  end

  // Any access other than the unlock write disarms, so stray bus cycles cannot retune the clock pin.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ccr_armed_reg <= 1'b0;
      clock_out_divider_reg <= 8'h00;
    end else begin
      ccr_armed_reg <= (wr_ccr && ccr_unlock) || (ccr_armed_reg && !wr_en && !rd_en);
      if (ccr_take) begin
        clock_out_divider_reg <= wdata;
      end
    end
  end

  // ----------------------------------------
  // Read port and outputs
  // ----------------------------------------
  always_comb begin
    read_mux = 8'h00;
    if (data_sel) begin
      read_mux = data_mem[{data_obj, data_byte}];
    end else if (desc_sel) begin
      read_mux = addr[0] ? desc_id[desc_obj][10:3] :
                 {desc_id[desc_obj][2:0], desc_rtr[desc_obj], desc_dlc[desc_obj]};
    end else begin
      case (addr)
        `ADDR_TX_OUTPUT_CONFIG: read_mux = tx_output_config_reg;
        `ADDR_RX_IRQ_ENABLE_LOW: read_mux = rx_irq_enable_low_reg;
        `ADDR_RX_IRQ_ENABLE_HIGH: read_mux = rx_irq_enable_high_reg;
        `ADDR_RX_READY_LOW: read_mux = rx_ready_reg[7:0];
        `ADDR_RX_READY_HIGH: read_mux = rx_ready_reg[15:8];
        `ADDR_IRQ_SOURCE_ENABLE: read_mux = irq_source_enable_reg;
        `ADDR_TX_REQUEST_LOW: read_mux = tx_req_reg[7:0];
        `ADDR_TX_REQUEST_HIGH: read_mux = tx_req_reg[15:8];
        `ADDR_OPERATING_CONTROL: read_mux = operating_control_reg;
        `ADDR_CLOCK_OUT_DIVIDER: read_mux = clock_out_divider_reg;
        default: read_mux = 8'h00;
      endcase
    end
  end

  wire line_bit = (state_reg == ST_TX) ? tx_bit : 1'b1;
  wire irq_rx = irq_source_enable_reg[`IRQ_RX_BIT] && (|(rx_ready_reg & rx_irq_mask));
  wire irq_tc = irq_source_enable_reg[`IRQ_TX_DONE_BIT] && operating_control_reg[`MODE_TX_DONE_BIT];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
      irq_n_reg <= 1'b1;
      tx_pin_reg <= 1'b1;
    end else begin
      rdata_reg <= rd_en ? read_mux : 8'h00;
      irq_n_reg <= !(irq_rx || irq_tc);
      tx_pin_reg <= line_bit ^ tx_output_config_reg[`OC_INVERT_BIT];
    end
  end

  assign clkif.sel = clock_out_divider_reg[3:0];
  clock_out_gen u_clock_out_gen (
    .mclk(mclk),
    .rstn(rstn),
    .port(clkif.gen)
  );
  // Ratio 1 cannot come from a flip-flop, so the oscillator clock is passed straight through.
  assign clk_out = (clock_out_divider_reg[3:0] == 4'h0) ? mclk : clkif.clk_q;
  assign rdata = rdata_reg;
  assign irq_n = irq_n_reg;
  assign tx_output_pin = tx_pin_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_tx_done_flag;
    @(posedge mclk) disable iff (!rstn) tx_done |=> operating_control_reg[`MODE_TX_DONE_BIT];
  endproperty
  a_tx_done_flag: assert property (p_tx_done_flag) else $error("tx done flag not set");
  property p_req_cleared;
    @(posedge mclk) disable iff (!rstn) (tx_done && !wr_en && !rx_answer) |=> !tx_req_reg[$past(cur_obj_reg)];
  endproperty
  a_req_cleared: assert property (p_req_cleared) else $error("request bit not cleared");
  property p_init_holds;
    @(posedge mclk) disable iff (!rstn) (!link_enable && !wr_mode) |=> (state_reg == ST_IDLE) [*2];
  endproperty
  a_init_holds: assert property (p_init_holds) else $error("link active in init mode");
  property p_priority;
    @(posedge mclk) disable iff (!rstn) tx_start |-> (higher_pending == 16'h0) ##1 (cur_obj_reg == $past(pick));
  endproperty
  a_priority: assert property (p_priority) else $error("lower object started first");
  property p_ccr_reject;
    @(posedge mclk) disable iff (!rstn) (wr_ccr && !ccr_armed_reg) |=> $stable(clock_out_divider_reg);
  endproperty
  a_ccr_reject: assert property (p_ccr_reject) else $error("unprotected clock write took effect");
  property p_ccr_accept;
    @(posedge mclk) disable iff (!rstn) (wr_ccr && ccr_unlock) ##1 (wr_ccr && !ccr_unlock)
      |=> (clock_out_divider_reg == $past(wdata));
  endproperty
  a_ccr_accept: assert property (p_ccr_accept) else $error("protected clock write lost");
  property p_idle_recessive;
    @(posedge mclk) disable iff (!rstn) (state_reg != ST_TX) [*2]
      |-> (tx_output_pin == !$past(tx_output_config_reg[`OC_INVERT_BIT]));
  endproperty
  a_idle_recessive: assert property (p_idle_recessive) else $error("pin not recessive while idle");
  property p_rx_irq;
    @(posedge mclk) disable iff (!rstn) (irq_source_enable_reg[`IRQ_RX_BIT] && |(rx_ready_reg & rx_irq_mask)) [*2]
      |-> !irq_n;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("reception interrupt missing");
  property p_store_ready;
    @(posedge mclk) disable iff (!rstn) rx_store |=> rx_ready_reg[$past(obj_data)] && !desc_rtr[$past(obj_data)];
  endproperty
  a_store_ready: assert property (p_store_ready) else $error("stored frame not flagged");
  c_tx_frame: cover property (@(posedge mclk) disable iff (!rstn) tx_done);
  c_rx_store: cover property (@(posedge mclk) disable iff (!rstn) rx_store);
  c_auto_answer: cover property (@(posedge mclk) disable iff (!rstn) rx_answer);
  c_ccr_take: cover property (@(posedge mclk) disable iff (!rstn) ccr_take);
endmodule : can_mo_ctrl

// ==== bench/can_node.sv ====
// Bus node model behind the transceiver: sends frames to the controller and logs the frames it sends.
// Assumes unstuffed frames, a bit time of BC mclk cycles and a bus pulled recessive.
`timescale 1ns/1ns
module can_node #(
  parameter int BC = 4
)(
  input wire logic mclk,
  input wire logic tx_pin,
  output logic rx_pin
);
  logic drv = 1'b1;
  logic [79:0] log_q[$];
  // A dominant 0 from either party wins, so the controller also hears its own bits.
  assign rx_pin = tx_pin & drv;
  function automatic int nbits(input logic [79:0] f);
    return f[68] ? 0 : 8 * ((f[67:64] > 4'h8) ? 8 : int'(f[67:64]));
  endfunction : nbits
  task automatic send(input logic [79:0] f);
    logic [80:0] g;
    g = {1'b0, f};
    @(posedge mclk);
    while (!rx_pin) @(posedge mclk);
    for (int i = 80; i > 63 - nbits(f); i--) begin
      drv <= g[i];
      repeat (BC) @(posedge mclk);
    end
    drv <= 1'b1;
    repeat (10 * BC) @(posedge mclk);
  endtask : send
  // The data length is only known once the header is in, so the bound is re-read each bit.
  initial forever begin
    logic [80:0] g;
    g = '0;
    @(negedge tx_pin);
    repeat (BC / 2) @(posedge mclk);
    for (int i = 80; i > 63 - nbits(g[79:0]); i--) begin
      g[i] = tx_pin;
      repeat (BC) @(posedge mclk);
    end
    log_q.push_back(g[79:0]);
    repeat (10 * BC) @(posedge mclk);
  end
endmodule : can_node

// ==== bench/full_can_message_object_controller_tb.sv ====
// Bench for the message object controller: registers, clock output, frames out and in.
// Assumes the bus node model on the pins and a bit time of four clock cycles.
`timescale 1ns/1ns
module full_can_message_object_controller_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, v, w;
  logic rx_pin, tx_output_pin, clk_out, irq_n;
  logic [15:0] tg;
  logic [63:0] d1, d2, d3, d5;
  logic [7:0] ra[4] = '{8'h02, 8'h06, 8'h07, 8'h0a};
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  can_mo_ctrl #(.BIT_CYCLES(4)) dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .rx_pin(rx_pin), .tx_output_pin(tx_output_pin), .clk_out(clk_out), .irq_n(irq_n));
  can_node #(.BC(4)) node_u (.mclk(mclk), .tx_pin(tx_output_pin), .rx_pin(rx_pin));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  // ----
  // Bus cycles and comparisons
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  // Two writes to one address with the strobe held, so the second follows with no gap.
  task automatic wr2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d0;
    @(posedge mclk);
    wdata <= d1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr2
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd
  task automatic chk_wide(input logic [79:0] g, input logic [79:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_wide
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    chk_wide({72'h0, g}, {72'h0, e});
  endtask : chk_reg
  function automatic logic [79:0] frm(input logic [10:0] id, input logic r, input logic [3:0] l, input logic [63:0] d);
    for (int k = (r ? 0 : ((l > 4'h8) ? 8 : int'(l))); k < 8; k++) d[63 - 8 * k -: 8] = 8'h00;
    return {id, r, l, d};
  endfunction : frm
  function automatic logic [15:0] exp_tog(input logic [3:0] c);
    return c[3] ? 16'h0 : 16'(840 / c);
  endfunction : exp_tog
  task automatic obj(input int n, input logic [10:0] id, input logic r, input logic [3:0] l, input logic [63:0] d);
    wr(8'(8'h20 + 2 * n), {id[2:0], r, l});
    wr(8'(8'h21 + 2 * n), id[10:3]);
    for (int k = 7; k >= 0; k--) wr(8'(8'h80 + 8 * n + k), d[63 - 8 * k -: 8]);
  endtask : obj
  task automatic count_tog(output logic [15:0] n);
    logic p;
    n = 16'h0;
    repeat (4) @(negedge mclk);
    p = clk_out;
    repeat (840) begin
      @(negedge mclk);
      n += 16'(clk_out != p);
      p = clk_out;
    end
  endtask : count_tog
  task automatic wait_frames(input int k);
    for (int i = 0; i < 3000 && node_u.log_q.size() < k; i++) @(posedge mclk);
    repeat (60) @(posedge mclk);
  endtask : wait_frames
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // ----
  // Scenarios
  // ----
  initial begin
    w = 8'($urandom(32'h53f4084b));
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h10, v);
    chk_reg(v, 8'h03);
    foreach (ra[i]) begin
      w = 8'($urandom);
      wr(ra[i], w);
      rd(ra[i], v);
      chk_reg(v, w);
    end
    wr(8'h1e, 8'hff);
    rd(8'h1e, v);
    chk_reg(v, 8'h00);
    wr(8'h02, 8'h1c);
    repeat (3) @(posedge mclk);
    chk_wide(80'(tx_output_pin), 80'h0);
    wr(8'h02, 8'h18);
    repeat (3) @(posedge mclk);
    chk_wide(80'(tx_output_pin), 80'h1);
    // Odd codes follow the unlock back to back, even codes after an idle cycle.
    for (int c = 1; c < 9; c++) begin
      if (c[0]) begin
        wr2(8'h14, 8'h80, 8'(c));
      end else begin
        wr(8'h14, 8'h80);
        wr(8'h14, 8'(c));
      end
      count_tog(tg);
      chk_wide(80'(tg), 80'(exp_tog(4'(c))));
    end
    // An unlock followed by a read must not open the register.
    wr(8'h14, 8'h80);
    rd(8'h10, v);
    wr(8'h14, 8'h01);
    wr(8'h14, 8'h02);
    count_tog(tg);
    chk_wide(80'(tg), 80'h0);
    for (int n = 0; n < 16; n++) obj(n, 11'(11'h700 + n), 1'b0, 4'h0, 64'h0);
    d5 = {$urandom, $urandom};
    d3 = {$urandom, $urandom};
    d2 = {$urandom, $urandom};
    obj(5, 11'h65a, 1'b0, 4'h8, d5);
    obj(4, 11'h1b3, 1'b1, 4'h0, 64'h0);
    obj(3, 11'h0c7, 1'b0, 4'h1, d3);
    node_u.log_q.delete();
    wr(8'h0a, 8'h80);
    wr(8'h0c, 8'h38);
    repeat (200) @(posedge mclk);
    chk_wide(80'(node_u.log_q.size()), 80'h0);
    wr(8'h10, 8'h00);
    wait_frames(3);
    chk_wide(node_u.log_q[0], frm(11'h65a, 1'b0, 4'h8, d5));
    chk_wide(node_u.log_q[1], frm(11'h1b3, 1'b1, 4'h0, 64'h0));
    chk_wide(node_u.log_q[2], frm(11'h0c7, 1'b0, 4'h1, d3));
    rd(8'h0c, v);
    chk_reg(v, 8'h00);
    rd(8'h10, v);
    chk_reg(v, 8'h20);
    chk_wide(80'(irq_n), 80'h0);
    wr(8'h10, 8'h00);
    wr(8'h0a, 8'h01);
    wr(8'h06, 8'h02);
    obj(1, 11'h123, 1'b0, 4'h2, 64'h0);
    obj(2, 11'h2aa, 1'b1, 4'h2, d2);
    d1 = {$urandom, $urandom};
    node_u.send(frm(11'h123, 1'b0, 4'h3, d1));
    repeat (20) @(posedge mclk);
    chk_wide(80'(irq_n), 80'h0);
    rd(8'h08, v);
    chk_reg(v, 8'h02);
    rd(8'h22, v);
    chk_reg(v, 8'h63);
    rd(8'h8a, v);
    chk_reg(v, d1[47:40]);
    node_u.log_q.delete();
    node_u.send(frm(11'h2aa, 1'b1, 4'h0, 64'h0));
    wait_frames(1);
    chk_wide(node_u.log_q[0], frm(11'h2aa, 1'b0, 4'h2, d2));
    // A remote frame to a data object and data to a remote object both go unused.
    node_u.log_q.delete();
    node_u.send(frm(11'h123, 1'b1, 4'h0, 64'h0));
    node_u.send(frm(11'h1b3, 1'b0, 4'h1, d3));
    repeat (200) @(posedge mclk);
    chk_wide(80'(node_u.log_q.size()), 80'h0);
    rd(8'h08, v);
    chk_reg(v, 8'h02);
    wr(8'h28, 8'h61);
    node_u.send(frm(11'h1b3, 1'b0, 4'h1, d3));
    repeat (20) @(posedge mclk);
    rd(8'h08, v);
    chk_reg(v, 8'h12);
    rd(8'ha0, v);
    chk_reg(v, d3[63:56]);
    complete_run();
  end
endmodule : full_can_message_object_controller_tb
